//--- tmcr_pkg.sv
// Constants, register indices and field layout of the timer mode and control block
package tmcr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_ENABLE   = 8'h00;
   localparam logic [7:0] IDX_MODE     = 8'h01;
   localparam logic [7:0] IDX_COV      = 8'h02;
   localparam logic [7:0] IDX_SPLIT    = 8'h03;
   localparam logic [7:0] IDX_CMD_CLR  = 8'h04;
   localparam logic [7:0] IDX_CMD_SET  = 8'h05;
   localparam logic [7:0] IDX_BV_CLR   = 8'h06;
   localparam logic [7:0] IDX_BV_SET   = 8'h07;
   localparam logic [7:0] IDX_COUNT    = 8'h08;
   localparam logic [7:0] IDX_CYCLE    = 8'h09;
   localparam logic [7:0] IDX_CYC_BUF  = 8'h0A;
   localparam logic [7:0] IDX_CMP_BUF0 = 8'h0B;
   localparam logic [7:0] IDX_CMP_VAL0 = 8'h0E;
   localparam logic [7:0] IDX_LAST     = 8'h10;
   // Field positions
   localparam int MODE_LSB   = 0;
   localparam int AUTO_BIT   = 3;
   localparam int CEN_LSB    = 4;
   localparam int DIR_BIT    = 0;
   localparam int LOCK_BIT   = 1;
   localparam int CMD_LSB    = 2;
   localparam int BV_CYC_BIT = 0;
   localparam int BV_CMP_LSB = 1;
   // Mode codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_FREQ   = 3'h1;
   localparam logic [2:0] MODE_SINGLE = 3'h3;
   localparam logic [2:0] MODE_DS_TOP = 3'h5;
   localparam logic [2:0] MODE_DS_BTH = 3'h6;
   localparam logic [2:0] MODE_DS_BOT = 3'h7;
   // Command codes
   localparam logic [1:0] CMD_NONE    = 2'h0;
   localparam logic [1:0] CMD_UPDATE  = 2'h1;
   localparam logic [1:0] CMD_RESTART = 2'h2;
   localparam logic [1:0] CMD_RESET   = 2'h3;
   // Reset values
   localparam logic [7:0]  RST_CTRL  = 8'h00;
   localparam logic [15:0] RST_CYCLE = 16'hFFFF;
   localparam logic [15:0] RST_ZERO  = 16'h0000;
   // Read answer latency in cycles after the request edge
   localparam int READ_LATENCY = 1;
endpackage

//--- tmcr_top.sv
// Timer mode, command, lock, direction and buffer-valid control with Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none
module tmcr_top
   import tmcr_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int NCH   = 3
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Avalon-MM slave
   input  wire logic [6:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [3:0]        avs_byteenable,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // Waveform and events
   output logic      [NCH-1:0]    waveform_output_n,
   output logic      [NCH-1:0]    pin_override_n,
   output logic                   update_event,
   output logic                   overflow_event
);
   localparam int HW = WIDTH / 2;

   // Refuse widths and channel counts that the decode and lane logic cannot serve
   if (WIDTH != 16 || NCH != 3) begin : g_param_check
      $error("tmcr_top serves only WIDTH 16 and NCH 3");
   end

   // Byte-lane merge for 16-bit registers
   function automatic logic [WIDTH-1:0] lane_merge(input logic [WIDTH-1:0] old_v,
                                                   input logic [31:0] wd,
                                                   input logic [3:0] be);
      logic [WIDTH-1:0] r;
      r = old_v;
      if (be[0]) begin
         r[HW-1:0] = wd[HW-1:0];
      end
      if (be[1]) begin
         r[WIDTH-1:HW] = wd[WIDTH-1:HW];
      end
      return r;
   endfunction

   // Register state
   logic                 enable_reg;
   logic [2:0]           waveform_gen_select;
   logic                 auto_update_lock;
   logic [NCH-1:0]       compare_output_enable_n;
   logic [NCH-1:0]       compare_output_value_n;
   logic                 split_mode_enable;
   logic                 lock_buffer_update;
   logic                 dir_reg;
   logic                 cycle_buffer_valid;
   logic [NCH-1:0]       compare_buffer_valid_n;
   logic [WIDTH-1:0]     counter_value;
   logic [WIDTH-1:0]     cycle_length;
   logic [WIDTH-1:0]     cycle_length_buffer;
   logic [WIDTH-1:0]     compare_buffer_n [NCH];
   logic [WIDTH-1:0]     compare_value_n  [NCH];
   logic                 rd_done_reg;

   // Bus decode
   logic       addr_ok;
   logic [7:0] idx;
   logic       wr;
   logic       wr0;
   logic [1:0] cmd;
   logic       cmd_wr;
   logic       force_update;
   logic       force_restart;
   logic       hard_reset;
   assign addr_ok = (avs_address[1:0] == 2'h0) && ({1'b0, avs_address[6:2]} <= IDX_LAST);
   assign idx     = {3'h0, avs_address[6:2]};
   assign wr      = avs_write && addr_ok;
   assign wr0     = wr && avs_byteenable[0];
   assign cmd     = avs_writedata[CMD_LSB+1:CMD_LSB];
   assign cmd_wr  = wr0 && (idx == IDX_CMD_CLR || idx == IDX_CMD_SET);
   assign force_update  = cmd_wr && cmd == CMD_UPDATE;
   assign force_restart = cmd_wr && cmd == CMD_RESTART;
   assign hard_reset    = cmd_wr && cmd == CMD_RESET && !enable_reg;

   // Counter events
   logic             run;
   logic             is_dual;
   logic [WIDTH-1:0] top_val;
   logic             at_top;
   logic             at_bot;
   logic             hw_update;
   logic             hw_ovf;
   logic             upd_cond;
   logic             xfer;
   logic             all_bv;
   assign run     = enable_reg && !split_mode_enable;
   assign is_dual = waveform_gen_select >= MODE_DS_TOP;
   assign top_val = (waveform_gen_select == MODE_FREQ) ? compare_value_n[0] : cycle_length;
   assign at_top  = counter_value == top_val;
   assign at_bot  = counter_value == RST_ZERO;

   always_comb begin
      hw_update = 1'b0;
      hw_ovf    = 1'b0;
      case (waveform_gen_select)
         MODE_NORMAL, MODE_FREQ: begin
            hw_update = dir_reg ? at_bot : at_top;
            hw_ovf    = hw_update;
         end
         MODE_SINGLE: begin
            hw_update = at_bot;
            hw_ovf    = at_bot;
         end
         MODE_DS_TOP: begin
            hw_update = at_bot && dir_reg;
            hw_ovf    = at_top && !dir_reg;
         end
         MODE_DS_BTH: begin
            hw_update = at_bot && dir_reg;
            hw_ovf    = (at_top && !dir_reg) || (at_bot && dir_reg);
         end
         MODE_DS_BOT: begin
            hw_update = at_bot && dir_reg;
            hw_ovf    = hw_update;
         end
         default: begin
            hw_update = 1'b0;
            hw_ovf    = 1'b0;
         end
      endcase
   end

   assign upd_cond = ((run && hw_update) || force_update) && !split_mode_enable;
   assign xfer     = upd_cond && !lock_buffer_update;
   assign all_bv   = &(compare_buffer_valid_n | ~compare_output_enable_n);

   // Enable and mode control
   always_ff @(posedge clk) begin
      if (srst) begin
         enable_reg              <= 1'b0;
         waveform_gen_select     <= RST_CTRL[2:0];
         auto_update_lock        <= 1'b0;
         compare_output_enable_n <= RST_CTRL[NCH-1:0];
         compare_output_value_n  <= RST_CTRL[NCH-1:0];
         split_mode_enable       <= 1'b0;
      end else if (wr0) begin
         if (idx == IDX_ENABLE) begin
            enable_reg <= avs_writedata[0];
         end else if (idx == IDX_MODE) begin
            waveform_gen_select     <= avs_writedata[MODE_LSB+2:MODE_LSB];
            auto_update_lock        <= avs_writedata[AUTO_BIT];
            compare_output_enable_n <= avs_writedata[CEN_LSB+NCH-1:CEN_LSB];
         end else if (idx == IDX_COV) begin
            compare_output_value_n <= avs_writedata[NCH-1:0];
         end else if (idx == IDX_SPLIT) begin
            split_mode_enable <= avs_writedata[0];
         end
      end
   end

   // Lock bit: hardware auto-lock wins over software writes
   always_ff @(posedge clk) begin
      if (srst || hard_reset) begin
         lock_buffer_update <= 1'b0;
      end else if (auto_update_lock) begin
         lock_buffer_update <= xfer || !all_bv;
      end else if (wr0 && idx == IDX_CMD_SET && avs_writedata[LOCK_BIT]) begin
         lock_buffer_update <= 1'b1;
      end else if (wr0 && idx == IDX_CMD_CLR && avs_writedata[LOCK_BIT]) begin
         lock_buffer_update <= 1'b0;
      end
   end

   // Direction: restart, then hardware turning points, then software
   always_ff @(posedge clk) begin
      if (srst || hard_reset || force_restart) begin
         dir_reg <= 1'b0;
      end else if (run && is_dual && at_top && !dir_reg) begin
         dir_reg <= 1'b1;
      end else if (run && is_dual && at_bot && dir_reg) begin
         dir_reg <= 1'b0;
      end else if (run && waveform_gen_select == MODE_SINGLE) begin
         dir_reg <= 1'b0;
      end else if (wr0 && idx == IDX_CMD_SET && avs_writedata[DIR_BIT]) begin
         dir_reg <= 1'b1;
      end else if (wr0 && idx == IDX_CMD_CLR && avs_writedata[DIR_BIT]) begin
         dir_reg <= 1'b0;
      end
   end

   // Counter; split mode runs two independent down-counting halves
   always_ff @(posedge clk) begin
      if (srst || hard_reset || force_restart) begin
         counter_value <= RST_ZERO;
      end else if (wr && idx == IDX_COUNT) begin
         counter_value <= lane_merge(counter_value, avs_writedata, avs_byteenable);
      end else if (enable_reg && split_mode_enable) begin
         counter_value[HW-1:0] <= (counter_value[HW-1:0] == '0) ?
            cycle_length[HW-1:0] : counter_value[HW-1:0] - 1'b1;
         counter_value[WIDTH-1:HW] <= (counter_value[WIDTH-1:HW] == '0) ?
            cycle_length[WIDTH-1:HW] : counter_value[WIDTH-1:HW] - 1'b1;
      end else if (run && waveform_gen_select != 3'h2 && waveform_gen_select != 3'h4) begin
         if (is_dual) begin
            if ((!dir_reg && !at_top) || (dir_reg && at_bot)) begin
               counter_value <= counter_value + 1'b1;
            end else begin
               counter_value <= counter_value - 1'b1;
            end
         end else if (!dir_reg || waveform_gen_select == MODE_SINGLE) begin
            counter_value <= at_top ? RST_ZERO : counter_value + 1'b1;
         end else begin
            counter_value <= at_bot ? top_val : counter_value - 1'b1;
         end
      end
   end

   // Period buffer, valid flag and live period
   always_ff @(posedge clk) begin
      if (srst || hard_reset) begin
         cycle_length        <= RST_CYCLE;
         cycle_length_buffer <= RST_CYCLE;
         cycle_buffer_valid  <= 1'b0;
      end else begin
         if (wr && idx == IDX_CYCLE && split_mode_enable) begin
            cycle_length <= lane_merge(cycle_length, avs_writedata, avs_byteenable);
         end else if (xfer) begin
            cycle_length <= cycle_length_buffer;
         end
         if (wr && idx == IDX_CYC_BUF) begin
            cycle_length_buffer <= lane_merge(cycle_length_buffer, avs_writedata,
                                              avs_byteenable);
         end
         if (wr && idx == IDX_CYC_BUF) begin
            cycle_buffer_valid <= 1'b1;
         end else if (wr0 && idx == IDX_BV_SET && avs_writedata[BV_CYC_BIT]) begin
            cycle_buffer_valid <= 1'b1;
         end else if (xfer) begin
            cycle_buffer_valid <= 1'b0;
         end else if (wr0 && idx == IDX_BV_CLR && avs_writedata[BV_CYC_BIT]) begin
            cycle_buffer_valid <= 1'b0;
         end
      end
   end

   // Compare buffers, valid flags and live compare values
   always_ff @(posedge clk) begin
      for (int n = 0; n < NCH; n++) begin
         if (srst || hard_reset) begin
            compare_buffer_n[n]       <= RST_ZERO;
            compare_value_n[n]        <= RST_ZERO;
            compare_buffer_valid_n[n] <= 1'b0;
         end else begin
            if (wr && idx == IDX_CMP_BUF0 + 8'(n) && split_mode_enable) begin
               compare_value_n[n] <= lane_merge(compare_value_n[n], avs_writedata,
                                                avs_byteenable);
            end else if (xfer) begin
               compare_value_n[n] <= compare_buffer_n[n];
            end
            if (wr && idx == IDX_CMP_BUF0 + 8'(n) && !split_mode_enable) begin
               compare_buffer_n[n] <= lane_merge(compare_buffer_n[n], avs_writedata,
                                                 avs_byteenable);
            end
            if (wr && idx == IDX_CMP_BUF0 + 8'(n) && !split_mode_enable) begin
               compare_buffer_valid_n[n] <= 1'b1;
            end else if (wr0 && idx == IDX_BV_SET && avs_writedata[BV_CMP_LSB+n]) begin
               compare_buffer_valid_n[n] <= 1'b1;
            end else if (xfer) begin
               compare_buffer_valid_n[n] <= 1'b0;
            end else if (wr0 && idx == IDX_BV_CLR && avs_writedata[BV_CMP_LSB+n]) begin
               compare_buffer_valid_n[n] <= 1'b0;
            end
         end
      end
   end

   // Waveform generator and pin routing
   always_ff @(posedge clk) begin
      for (int n = 0; n < NCH; n++) begin
         if (srst) begin
            waveform_output_n[n] <= 1'b0;
            pin_override_n[n]    <= 1'b0;
         end else begin
            pin_override_n[n] <= compare_output_enable_n[n] &&
                                 waveform_gen_select != MODE_NORMAL;
            if (!enable_reg) begin
               waveform_output_n[n] <= compare_output_value_n[n];
            end else if (split_mode_enable) begin
               waveform_output_n[n] <= waveform_output_n[n];
            end else if (waveform_gen_select == MODE_FREQ) begin
               if (counter_value == compare_value_n[n]) begin
                  waveform_output_n[n] <= !waveform_output_n[n];
               end
            end else if (waveform_gen_select == MODE_SINGLE || is_dual) begin
               waveform_output_n[n] <= counter_value < compare_value_n[n];
            end
         end
      end
   end

   // Event pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         update_event   <= 1'b0;
         overflow_event <= 1'b0;
      end else begin
         update_event   <= upd_cond;
         overflow_event <= run && hw_ovf;
      end
   end

   // Read path: one wait cycle, data registered
   assign avs_waitrequest = avs_read && !rd_done_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_done_reg  <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_done_reg <= avs_read && !rd_done_reg;
         if (avs_read && !rd_done_reg) begin
            avs_readdata <= 32'h0000_0000;
            if (!addr_ok) begin
               avs_readdata <= 32'h0000_0000;
            end else if (idx == IDX_ENABLE) begin
               avs_readdata[0] <= enable_reg;
            end else if (idx == IDX_MODE) begin
               avs_readdata[7:0] <= {1'b0, compare_output_enable_n, auto_update_lock,
                                     waveform_gen_select};
            end else if (idx == IDX_COV) begin
               avs_readdata[NCH-1:0] <= compare_output_value_n;
            end else if (idx == IDX_SPLIT) begin
               avs_readdata[0] <= split_mode_enable;
            end else if (idx == IDX_CMD_CLR || idx == IDX_CMD_SET) begin
               avs_readdata[1:0] <= {lock_buffer_update, dir_reg};
            end else if (idx == IDX_BV_CLR || idx == IDX_BV_SET) begin
               avs_readdata[NCH:0] <= {compare_buffer_valid_n, cycle_buffer_valid};
            end else if (idx == IDX_COUNT) begin
               avs_readdata[WIDTH-1:0] <= counter_value;
            end else if (idx == IDX_CYCLE) begin
               avs_readdata[WIDTH-1:0] <= cycle_length;
            end else if (idx == IDX_CYC_BUF) begin
               avs_readdata[WIDTH-1:0] <= cycle_length_buffer;
            end else if (idx >= IDX_CMP_BUF0 && idx < IDX_CMP_VAL0) begin
               avs_readdata[WIDTH-1:0] <= split_mode_enable ?
                  compare_value_n[idx[1:0] - 2'h3] : compare_buffer_n[idx[1:0] - 2'h3];
            end else begin
               avs_readdata[WIDTH-1:0] <= compare_value_n[idx[1:0] - 2'h2];
            end
         end
      end
   end

   // Checks
   localparam int RD_MIN = 1;
   localparam int RD_MAX = 1;
   sequence s_cov_write;
      wr0 && idx == IDX_COV && !enable_reg;
   endsequence
   sequence s_locked_update;
      upd_cond && lock_buffer_update;
   endsequence

   a_read_answer: assert property (@(posedge clk) disable iff (srst)
      avs_read && avs_waitrequest |-> ##[RD_MIN:RD_MAX] !avs_waitrequest)
      else $error("read not answered in one cycle");
   a_cmd_reads_zero: assert property (@(posedge clk) disable iff (srst)
      avs_read && !avs_waitrequest && (idx == IDX_CMD_CLR || idx == IDX_CMD_SET) |->
      avs_readdata[3:2] == 2'h0)
      else $error("command field read nonzero");
   a_hard_reset_ignored: assert property (@(posedge clk) disable iff (srst)
      cmd_wr && cmd == CMD_RESET && enable_reg && !xfer |=>
      cycle_length == $past(cycle_length))
      else $error("hard reset acted while enabled");
   a_lock_holds_cmp: assert property (@(posedge clk) disable iff (srst || hard_reset)
      s_locked_update |=> compare_value_n[0] == $past(compare_value_n[0]))
      else $error("locked update transferred a buffer");
   a_update_copies: assert property (@(posedge clk) disable iff (srst || hard_reset)
      xfer |=> cycle_length == $past(cycle_length_buffer) && !cycle_buffer_valid)
      else $error("period not copied on update");
   a_bv_write_sets: assert property (@(posedge clk) disable iff (srst || hard_reset)
      wr && idx == IDX_CMP_BUF0 && !split_mode_enable |=> compare_buffer_valid_n[0])
      else $error("compare buffer valid not set");
   a_restart_zeroes: assert property (@(posedge clk) disable iff (srst)
      force_restart |=> counter_value == RST_ZERO && !dir_reg)
      else $error("restart did not zero counter");
   a_normal_no_pin: assert property (@(posedge clk) disable iff (srst)
      (waveform_gen_select == MODE_NORMAL) [*2] |-> pin_override_n == '0)
      else $error("pin routed in normal mode");
   a_stopped_value: assert property (@(posedge clk) disable iff (srst)
      s_cov_write ##1 !enable_reg |=> waveform_output_n == $past(avs_writedata[NCH-1:0], 2))
      else $error("stopped output value not applied");
   a_force_update: assert property (@(posedge clk) disable iff (srst)
      force_update && !split_mode_enable |=> update_event)
      else $error("forced update gave no update");
endmodule
`default_nettype wire

//--- tmcr_tb.sv
// Self-checking bench for the timer mode and control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tmcr_pkg::*;
   logic        clk, srst, rd, wr, wq, upd, ovf;
   logic [6:0]  adr;
   logic [3:0]  be;
   logic [31:0] wd, rdat, q, seed;
   logic [2:0]  wo, po, v;
   int          failures, check_count, n_upd, m_buf[3], c_ovf, c_upd;
   localparam int MODES[6] = '{1, 3, 5, 6, 7, 0};
   tmcr_top dut (.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
      .waveform_output_n(wo), .pin_override_n(po), .update_event(upd), .overflow_event(ovf));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (upd === 1'b1) n_upd++;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input int exp, input string w);
      check_count++;
      if (got !== exp[31:0]) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low, then releases at that edge
   task ack;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 50);
      if (wq !== 1'b0) begin
         failures++;
         $display("[ERR] %0t bus timeout", $time);
         end_of_test;
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task wreg(input logic [7:0] i, input logic [31:0] d);
      @(posedge clk);
      adr <= {i[4:0], 2'h0};
      wd <= d;
      wr <= 1'b1;
      ack;
   endtask
   task rreg(input logic [7:0] i, input int exp, input string w);
      @(posedge clk);
      adr <= {i[4:0], 2'h0};
      rd <= 1'b1;
      ack;
      chk(q, exp, w);
   endtask
   initial begin
      srst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 7'h00; be = 4'hF; wd = 32'h0;
      seed = 32'hC3E0DEF0; failures = 0; check_count = 0; n_upd = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int i = 2; i < 8; i++) rreg(i[7:0], 0, "reset value");
      rreg(IDX_CYCLE, 16'hFFFF, "cycle reset");
      rreg(8'h1F, 0, "unmapped read");
      $display("test reset done");
      wreg(IDX_CMD_SET, 32'h3);
      rreg(IDX_CMD_SET, 3, "set lock dir");
      wreg(IDX_CMD_CLR, 32'h1);
      rreg(IDX_CMD_CLR, 2, "clear dir");
      for (int i = 0; i < 3; i++) begin
         m_buf[i] = int'(seed[15:0]);
         wreg(IDX_CMP_BUF0 + 8'(i), seed & 32'hFFFF);
         seed = lfsr(seed);
      end
      wreg(IDX_CYC_BUF, 32'h0123);
      rreg(IDX_BV_SET, 15, "valid flags");
      wreg(IDX_CMD_SET, 32'h4);
      rreg(IDX_BV_CLR, 15, "locked update");
      rreg(IDX_CMP_VAL0, 0, "locked compare");
      chk(n_upd, 1, "update event");
      wreg(IDX_CMD_CLR, 32'h2);
      wreg(IDX_CMD_CLR, 32'h4);
      rreg(IDX_BV_SET, 0, "flags after update");
      for (int i = 0; i < 3; i++) rreg(IDX_CMP_VAL0 + 8'(i), m_buf[i], "compare copy");
      rreg(IDX_CYCLE, 16'h0123, "cycle copy");
      wreg(IDX_BV_SET, 32'h5);
      wreg(IDX_BV_CLR, 32'h1);
      rreg(IDX_BV_SET, 4, "flag set clear");
      $display("test buffers done");
      wreg(IDX_COUNT, 32'h0055);
      wreg(IDX_CMD_SET, 32'h1);
      wreg(IDX_CMD_SET, 32'h8);
      rreg(IDX_COUNT, 0, "restart count");
      rreg(IDX_CMD_SET, 0, "restart dir");
      wreg(IDX_CMD_SET, 32'h2);
      wreg(IDX_ENABLE, 32'h1);
      wreg(IDX_CMD_SET, 32'hC);
      rreg(IDX_CMD_SET, 2, "reset ignored");
      wreg(IDX_ENABLE, 32'h0);
      wreg(IDX_CMD_CLR, 32'hC);
      rreg(IDX_CMD_SET, 0, "hard reset");
      $display("test commands done");
      for (int k = 0; k < 6; k++) begin
         v = seed[2:0];
         seed = lfsr(seed);
         wreg(IDX_MODE, {24'h0, 8'h50 | 8'(MODES[k])});
         wreg(IDX_COV, {29'h0, v});
         rreg(IDX_MODE, 8'h50 | MODES[k], "mode");
         chk(wo, v, "output value");
         chk(po, (MODES[k] == 0) ? 0 : 5, "pin routing");
      end
      // Normal mode, TOP 3: one update and one overflow every four cycles
      wreg(IDX_CYC_BUF, 32'h3);
      wreg(IDX_CMD_SET, 32'h4);
      wreg(IDX_ENABLE, 32'h1);
      c_ovf = 0;
      c_upd = 0;
      @(posedge clk);
      repeat (12) begin
         @(posedge clk);
         if (ovf === 1'b1) c_ovf++;
         if (upd === 1'b1) c_upd++;
      end
      wreg(IDX_ENABLE, 32'h0);
      chk(c_ovf, 3, "overflow count");
      chk(c_upd, 3, "update count");
      $display("test run done");
      wreg(IDX_MODE, 32'h18);
      rreg(IDX_CMD_SET, 2, "auto lock held");
      wreg(IDX_CMP_BUF0, 32'h0042);
      rreg(IDX_CMD_SET, 0, "auto lock freed");
      wreg(IDX_CMD_SET, 32'h4);
      rreg(IDX_CMD_SET, 2, "auto relock");
      rreg(IDX_CMP_VAL0, 16'h0042, "auto copy");
      wreg(IDX_SPLIT, 32'h1);
      rreg(IDX_SPLIT, 1, "split bit");
      $display("test modes done");
      end_of_test;
   end
endmodule
`default_nettype wire
